// File: include/pdma_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Shared constants of the PCI master DMA sequencer
// Assumes: 32-bit AXI4-Lite register bus, word aligned registers
// Notes:   Terminal count is counted in DWORDs
//////////////////////////////////////////////////////////////////////////////
package pdma_pkg;

	localparam int DW = 32;              // Data width
	localparam int AW = 8;               // Register address width
	localparam int FIFO_DEPTH = 4;       // Words held in the data FIFO
	localparam int TCW = 18;             // Terminal count width

	// Register byte offsets
	localparam logic [AW-1:0] OFS_CCS  = 8'h00;   // count_control_status
	localparam logic [AW-1:0] OFS_ADDR = 8'h04;   // Address counter
	localparam logic [AW-1:0] OFS_DIR  = 8'h08;   // Direction select

	// Field positions in count_control_status
	localparam int B_LRST    = 0;
	localparam int B_DISCARD = 1;
	localparam int B_INTENA  = 2;
	localparam int B_TCIDIS  = 3;
	localparam int B_DMAEN   = 4;
	localparam int B_BURST   = 5;
	localparam int B_INTIRQ  = 6;
	localparam int B_ERRPEND = 7;
	localparam int B_INTPEND = 8;
	localparam int B_ACTIVE  = 9;
	localparam int B_DONE    = 10;
	localparam int B_LOADED  = 11;
	localparam int B_TC_LO   = 14;
	localparam int B_DIR     = 0;        // In direction register

	// Reset values
	localparam logic [5:0]     CTRL_RST = 6'h00;
	localparam logic [TCW-1:0] TC_RST   = 18'h0_0000;
	localparam logic [DW-1:0]  ADDR_RST = 32'h0000_0000;

	// PCI bus commands and burst sizes
	localparam logic [3:0] CMD_MEM_RD = 4'h6;
	localparam logic [3:0] CMD_MEM_WR = 4'h7;
	localparam logic [2:0] LEN_BURST  = 3'h4;
	localparam logic [2:0] LEN_SINGLE = 3'h1;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		ST_IDLE, ST_RD_ISSUE, ST_RD_FILL, ST_RD_DRAIN,
		ST_WR_FILL, ST_WR_ISSUE, ST_WR_SEND, ST_STEP
	} pdma_state_t;

endpackage

// File: src/pdma_fifo.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: Small synchronous FIFO with valid/ready on both sides
// Assumes: Single clock, asynchronous active low reset
// Notes:   Output word is read straight from the storage flops
//////////////////////////////////////////////////////////////////////////////
module pdma_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 4
) (
	input  wire logic             clock_in,   // Clock
	input  wire logic             nrst_in,    // Async reset, low
	input  wire logic             flush_in,   // Drop all words
	input  wire logic             in_valid_in, // Write side valid
	output logic                  in_ready_out, // Not full
	input  wire logic [WIDTH-1:0] in_data_in, // Write data
	output logic                  out_valid_out, // Not empty
	input  wire logic             out_ready_in, // Read side ready
	output logic      [WIDTH-1:0] out_data_out, // Head word
	output logic [$clog2(DEPTH):0] count_out  // Words held
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [PW-1:0]    wp_r;
	logic [PW-1:0]    rp_r;
	logic [PW:0]      cnt_r;
	wire              push;
	wire              pop;

	// Handshake decode
	assign in_ready_out  = (cnt_r != (PW+1)'(DEPTH));
	assign out_valid_out = (cnt_r != '0);
	assign push          = in_valid_in & in_ready_out;
	assign pop           = out_valid_out & out_ready_in;
	assign out_data_out  = mem_r[rp_r];
	assign count_out     = cnt_r;

	// Storage
	always_ff @(posedge clock_in) begin
		if (push)
			mem_r[wp_r] <= in_data_in;
	end

	// Pointers and fill level
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else if (flush_in) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push)
				wp_r <= (wp_r == PW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
			if (pop)
				rp_r <= (rp_r == PW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
			cnt_r <= cnt_r + (PW+1)'(push) - (PW+1)'(pop);
		end
	end

	AST_FIFO_BOUND: assert property (@(posedge clock_in) disable iff (!nrst_in)
		cnt_r <= (PW+1)'(DEPTH)) else $error("FIFO overfilled");

endmodule

// File: src/pdma_axil.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: AXI4-Lite slave front end of the DMA register file
// Assumes: One write and one read under way at most
// Notes:   Unmapped offsets answer SLVERR, reads return zero
//////////////////////////////////////////////////////////////////////////////
module pdma_axil
	import pdma_pkg::*;
(
	input  wire logic          clock_in,      // Clock
	input  wire logic          nrst_in,       // Async reset, low
	input  wire logic [AW-1:0] awaddr_in,     // Write address
	input  wire logic          awvalid_in,    // Write address valid
	output logic               awready_out,   // Write address ready
	input  wire logic [DW-1:0] wdata_in,      // Write data
	input  wire logic [3:0]    wstrb_in,      // Byte strobes
	input  wire logic          wvalid_in,     // Write data valid
	output logic               wready_out,    // Write data ready
	output logic [1:0]         bresp_out,     // Write response
	output logic               bvalid_out,    // Write response valid
	input  wire logic          bready_in,     // Write response ready
	input  wire logic [AW-1:0] araddr_in,     // Read address
	input  wire logic          arvalid_in,    // Read address valid
	output logic               arready_out,   // Read address ready
	output logic [DW-1:0]      rdata_out,     // Read data
	output logic [1:0]         rresp_out,     // Read response
	output logic               rvalid_out,    // Read data valid
	input  wire logic          rready_in,     // Read data ready
	output logic               wr_en_out,     // Register write pulse
	output logic [AW-1:0]      wr_addr_out,   // Register write offset
	output logic [DW-1:0]      wr_data_out,   // Register write data
	output logic [3:0]         wr_strb_out,   // Register write strobes
	output logic               rd_en_out,     // Register read pulse
	output logic [AW-1:0]      rd_addr_out,   // Register read offset
	input  wire logic [DW-1:0] rd_data_in     // Register read data
);
	logic          aw_full_r, w_full_r, bvalid_r, rvalid_r;
	logic [AW-1:0] aw_r;
	logic [DW-1:0] wd_r, rdata_r;
	logic [3:0]    ws_r;
	logic [1:0]    bresp_r, rresp_r;
	wire           wr_go, rd_go, wr_hit, rd_hit;

	// Decode
	assign awready_out = ~aw_full_r;
	assign wready_out  = ~w_full_r;
	assign arready_out = ~rvalid_r;
	assign wr_go  = aw_full_r & w_full_r & ~bvalid_r;
	assign rd_go  = arvalid_in & ~rvalid_r;
	assign wr_hit = (aw_r == OFS_CCS) | (aw_r == OFS_ADDR) | (aw_r == OFS_DIR);
	assign rd_hit = (araddr_in == OFS_CCS) | (araddr_in == OFS_ADDR) |
		(araddr_in == OFS_DIR);
	assign wr_en_out   = wr_go & wr_hit;
	assign wr_addr_out = aw_r;
	assign wr_data_out = wd_r;
	assign wr_strb_out = ws_r;
	assign rd_en_out   = rd_go & rd_hit;
	assign rd_addr_out = araddr_in;
	assign bvalid_out  = bvalid_r;
	assign bresp_out   = bresp_r;
	assign rvalid_out  = rvalid_r;
	assign rresp_out   = rresp_r;
	assign rdata_out   = rdata_r;

	// Write channels and response
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			aw_full_r <= 1'b0;
			w_full_r  <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= RESP_OKAY;
			aw_r      <= '0;
			wd_r      <= '0;
			ws_r      <= '0;
		end else begin
			if (awvalid_in & ~aw_full_r) begin
				aw_full_r <= 1'b1;
				aw_r      <= awaddr_in;
			end
			if (wvalid_in & ~w_full_r) begin
				w_full_r <= 1'b1;
				wd_r     <= wdata_in;
				ws_r     <= wstrb_in;
			end
			if (wr_go) begin
				aw_full_r <= 1'b0;
				w_full_r  <= 1'b0;
				bvalid_r  <= 1'b1;
				bresp_r   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (bready_in)
				bvalid_r <= 1'b0;
		end
	end

	// Read channel
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rvalid_r <= 1'b0;
			rdata_r  <= '0;
			rresp_r  <= RESP_OKAY;
		end else if (rd_go) begin
			rvalid_r <= 1'b1;
			rdata_r  <= rd_hit ? rd_data_in : '0;
			rresp_r  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rready_in)
			rvalid_r <= 1'b0;
	end

endmodule

// File: src/pdma_top.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: PCI master DMA sequencer with registers and data FIFO
// Assumes: PCI bus phases are run by a master engine behind mst_* ports
// Notes:   Terminal count is the number of DWORDs left to move
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Address-loaded bit 11 sets when the address counter is written.
// - Address-loaded clears on done, on buffer discard, or on reset.
// - Address-loaded starts a DMA when enabled and no error pending.
// - Engine uses a four word 32-bit FIFO and three registers.
// - Device masters PCI reads and writes to memory or burst targets.
// - Read phase fetches four DWORDs per transaction if burst, else one.
// - Read phase is followed by passing the same count to local side.
// - Every DMA read transaction uses the memory read command.
// - Local side supplies DWORDs into the FIFO before PCI writes start.
// - Write phase sends four DWORDs per transaction if burst, else one.
// - Every DMA write transaction uses the memory write command.
// - Done flag sets on completion; clears on read, discard, or reset.
// - Burst bit high moves four DWORDs per transaction, low moves one.
// - Transfer begins when active: loaded, enabled and no error pending.
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
module pdma_top
	import pdma_pkg::*;
(
	input  wire logic          clock_in,        // PCI clock
	input  wire logic          nrst_in,         // PCI reset, low
	input  wire logic [AW-1:0] awaddr_in,       // AXI write address
	input  wire logic          awvalid_in,      // AXI write address valid
	output logic               awready_out,     // AXI write address ready
	input  wire logic [DW-1:0] wdata_in,        // AXI write data
	input  wire logic [3:0]    wstrb_in,        // AXI byte strobes
	input  wire logic          wvalid_in,       // AXI write data valid
	output logic               wready_out,      // AXI write data ready
	output logic [1:0]         bresp_out,       // AXI write response
	output logic               bvalid_out,      // AXI write resp valid
	input  wire logic          bready_in,       // AXI write resp ready
	input  wire logic [AW-1:0] araddr_in,       // AXI read address
	input  wire logic          arvalid_in,      // AXI read address valid
	output logic               arready_out,     // AXI read address ready
	output logic [DW-1:0]      rdata_out,       // AXI read data
	output logic [1:0]         rresp_out,       // AXI read response
	output logic               rvalid_out,      // AXI read valid
	input  wire logic          rready_in,       // AXI read ready
	output logic               mst_req_valid_out, // PCI transaction request
	input  wire logic          mst_req_ready_in, // Request taken
	output logic [3:0]         mst_cmd_out,     // PCI bus command
	output logic [DW-1:0]      mst_addr_out,    // PCI start address
	output logic [2:0]         mst_len_out,     // DWORDs in transaction
	input  wire logic          mst_rd_valid_in, // Read DWORD from PCI
	input  wire logic [DW-1:0] mst_rd_data_in,  // Read DWORD
	output logic               mst_rd_ready_out, // FIFO can take it
	output logic               mst_wr_valid_out, // Write DWORD to PCI
	output logic [DW-1:0]      mst_wr_data_out, // Write DWORD
	input  wire logic          mst_wr_ready_in, // PCI took the DWORD
	input  wire logic          mst_err_in,      // PCI error pending level
	input  wire logic          loc_irq_req_in,  // Local interrupt request
	output logic               loc_rx_valid_out, // DWORD to local side
	output logic [DW-1:0]      loc_rx_data_out, // DWORD to local side
	input  wire logic          loc_rx_ready_in, // Local side takes it
	input  wire logic          loc_tx_valid_in, // DWORD from local side
	input  wire logic [DW-1:0] loc_tx_data_in,  // DWORD from local side
	output logic               loc_tx_ready_out, // FIFO can take it
	output logic               loc_reset_n_out  // Local reset, low
);
	//////////////////////////////////////////////////////////////////////////
	// Register bus
	//////////////////////////////////////////////////////////////////////////
	logic              wr_en, rd_en;
	logic [AW-1:0]     wr_addr, rd_addr;
	logic [DW-1:0]     wr_data, rd_data;
	logic [3:0]        wr_strb;

	pdma_axil pdma_axil_inst (
		.clock_in    (clock_in),
		.nrst_in     (nrst_in),
		.awaddr_in   (awaddr_in),
		.awvalid_in  (awvalid_in),
		.awready_out (awready_out),
		.wdata_in    (wdata_in),
		.wstrb_in    (wstrb_in),
		.wvalid_in   (wvalid_in),
		.wready_out  (wready_out),
		.bresp_out   (bresp_out),
		.bvalid_out  (bvalid_out),
		.bready_in   (bready_in),
		.araddr_in   (araddr_in),
		.arvalid_in  (arvalid_in),
		.arready_out (arready_out),
		.rdata_out   (rdata_out),
		.rresp_out   (rresp_out),
		.rvalid_out  (rvalid_out),
		.rready_in   (rready_in),
		.wr_en_out   (wr_en),
		.wr_addr_out (wr_addr),
		.wr_data_out (wr_data),
		.wr_strb_out (wr_strb),
		.rd_en_out   (rd_en),
		.rd_addr_out (rd_addr),
		.rd_data_in  (rd_data)
	);

	//////////////////////////////////////////////////////////////////////////
	// Registers
	//////////////////////////////////////////////////////////////////////////
	logic [5:0]     ctrl_r;        // Bits 5..0 of count_control_status
	logic [TCW-1:0] count_r, count_nxt;
	logic [DW-1:0]  addr_r, addr_nxt;
	logic           dir_r;         // 1: local to PCI, 0: PCI to local
	logic           loaded_r, done_r, err_r;
	pdma_state_t    state_r, state_nxt;
	logic [2:0]     xfer_r;        // DWORDs moved in this transaction
	logic [2:0]     len_r;         // DWORDs planned for this transaction

	wire [DW-1:0] wmask = {{8{wr_strb[3]}}, {8{wr_strb[2]}},
		{8{wr_strb[1]}}, {8{wr_strb[0]}}};
	wire          wr_ccs   = wr_en & (wr_addr == OFS_CCS);
	wire          wr_adr   = wr_en & (wr_addr == OFS_ADDR);
	wire          wr_dir   = wr_en & (wr_addr == OFS_DIR);
	wire          rd_ccs   = rd_en & (rd_addr == OFS_CCS);
	wire [DW-1:0] ccs_rd;
	wire [DW-1:0] ccs_new  = (ccs_rd & ~wmask) | (wr_data & wmask);
	wire          discard  = wr_ccs & wr_strb[0] & wr_data[B_DISCARD];
	wire          active   = loaded_r & ctrl_r[B_DMAEN] & ~err_r;
	wire          intpend  = err_r | done_r | loc_irq_req_in;
	wire          finish   = (state_r == ST_STEP) && (count_nxt == '0);
	wire [2:0]    plan_len = ctrl_r[B_BURST] ?
		((count_r < TCW'(LEN_BURST)) ? count_r[2:0] : LEN_BURST) :
		LEN_SINGLE;

	// Read image of count_control_status; bits 13..12 stay zero
	assign ccs_rd = {count_r, 2'b00, loaded_r, done_r, active, intpend,
		err_r, loc_irq_req_in, ctrl_r};
	assign rd_data = (rd_addr == OFS_CCS)  ? ccs_rd :
		(rd_addr == OFS_ADDR) ? addr_r : {31'h0000_0000, dir_r};
	assign loc_reset_n_out = ctrl_r[B_LRST] & nrst_in;

	// Software-steered control bits and direction; error level sampled from mst_err_in
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			ctrl_r <= CTRL_RST;
			dir_r  <= 1'b0;
			err_r  <= 1'b0;
		end else begin
			err_r <= mst_err_in;
			if (wr_ccs)
				ctrl_r <= ccs_new[5:0] & ~(6'h01 << B_DISCARD);
			if (wr_dir & wr_strb[0])
				dir_r <= wr_data[B_DIR];
		end
	end

	// Address, count and status flags; a set wins over a clear
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			addr_r   <= ADDR_RST;
			count_r  <= TC_RST;
			loaded_r <= 1'b0;
			done_r   <= 1'b0;
		end else begin
			addr_r  <= addr_nxt;
			count_r <= count_nxt;
			if (wr_adr)
				loaded_r <= 1'b1;
			else if (finish | discard)
				loaded_r <= 1'b0;
			if (finish)
				done_r <= 1'b1;
			else if (rd_ccs | discard)
				done_r <= 1'b0;
		end
	end

	// Next address and count: per-transaction steps, then software writes
	always_comb begin
		addr_nxt  = addr_r;
		count_nxt = count_r;
		if (state_r == ST_STEP) begin
			addr_nxt  = addr_r + {27'h000_0000, len_r, 2'b00};
			count_nxt = count_r - TCW'(len_r);
		end
		if (wr_adr)
			addr_nxt = (addr_r & ~wmask) | (wr_data & wmask);
		if (wr_ccs)
			count_nxt = ccs_new[DW-1:B_TC_LO];
	end

	//////////////////////////////////////////////////////////////////////////
	// Data FIFO, shared by both directions
	//////////////////////////////////////////////////////////////////////////
	logic          f_in_valid, f_in_ready, f_out_valid, f_out_ready;
	logic [DW-1:0] f_in_data, f_out_data;
	logic [2:0]    f_count;
	wire           is_rd_fill = (state_r == ST_RD_FILL);
	wire           is_rd_drn  = (state_r == ST_RD_DRAIN);
	wire           is_wr_fill = (state_r == ST_WR_FILL);
	wire           is_wr_send = (state_r == ST_WR_SEND);
	wire           want_more  = (xfer_r != len_r);

	// Source and sink selection by phase
	assign f_in_valid = (is_rd_fill & mst_rd_valid_in & want_more) |
		(is_wr_fill & loc_tx_valid_in & want_more);
	assign f_in_data  = is_rd_fill ? mst_rd_data_in : loc_tx_data_in;
	assign mst_rd_ready_out = is_rd_fill & want_more & f_in_ready;
	assign loc_tx_ready_out = is_wr_fill & want_more & f_in_ready;
	assign loc_rx_valid_out = is_rd_drn & f_out_valid;
	assign mst_wr_valid_out = is_wr_send & f_out_valid;
	assign loc_rx_data_out  = f_out_data;
	assign mst_wr_data_out  = f_out_data;
	assign f_out_ready = (is_rd_drn & loc_rx_ready_in) |
		(is_wr_send & mst_wr_ready_in);

	pdma_fifo #(.WIDTH(DW), .DEPTH(FIFO_DEPTH)) pdma_fifo_inst (
		.clock_in      (clock_in),
		.nrst_in       (nrst_in),
		.flush_in      (discard),
		.in_valid_in   (f_in_valid),
		.in_ready_out  (f_in_ready),
		.in_data_in    (f_in_data),
		.out_valid_out (f_out_valid),
		.out_ready_in  (f_out_ready),
		.out_data_out  (f_out_data),
		.count_out     (f_count)
	);

	//////////////////////////////////////////////////////////////////////////
	// Transfer sequencer
	//////////////////////////////////////////////////////////////////////////
	wire in_beat  = f_in_valid & f_in_ready;
	wire out_beat = f_out_valid & f_out_ready;

	assign mst_req_valid_out = (state_r == ST_RD_ISSUE) |
		(state_r == ST_WR_ISSUE);
	assign mst_cmd_out  = dir_r ? CMD_MEM_WR : CMD_MEM_RD;
	assign mst_addr_out = addr_r;
	assign mst_len_out  = len_r;

	// Phase order: read fetches then drains; write fills then sends
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE:
				if (active && count_r != '0 && !discard)
					state_nxt = dir_r ? ST_WR_FILL : ST_RD_ISSUE;
			ST_RD_ISSUE:
				if (mst_req_ready_in)
					state_nxt = ST_RD_FILL;
			ST_RD_FILL:
				if (!want_more)
					state_nxt = ST_RD_DRAIN;
			ST_RD_DRAIN:
				if (f_count == 3'h0)
					state_nxt = ST_STEP;
			ST_WR_FILL:
				if (!want_more)
					state_nxt = ST_WR_ISSUE;
			ST_WR_ISSUE:
				if (mst_req_ready_in)
					state_nxt = ST_WR_SEND;
			ST_WR_SEND:
				if (f_count == 3'h0)
					state_nxt = ST_STEP;
			ST_STEP:
				state_nxt = ST_IDLE;
			default:
				state_nxt = ST_IDLE;
		endcase
		if (discard)
			state_nxt = ST_IDLE;
	end

	// State, planned length and beat counter
	always_ff @(posedge clock_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_r <= ST_IDLE;
			len_r   <= LEN_SINGLE;
			xfer_r  <= 3'h0;
		end else begin
			state_r <= state_nxt;
			if (state_r == ST_IDLE) begin
				len_r  <= plan_len;
				xfer_r <= 3'h0;
			end else if (in_beat)
				xfer_r <= xfer_r + 3'h1;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Checks
	//////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!nrst_in);

	AST_LOADED_SET: assert property (wr_adr |=> loaded_r)
		else $error("Address write did not mark address loaded");
	AST_LOADED_CLR: assert property (discard && !wr_adr |=> !loaded_r)
		else $error("Discard left address loaded");
	AST_START: assert property (state_r == ST_IDLE && active &&
		count_r != '0 && !discard |=> state_r != ST_IDLE)
		else $error("Active engine did not start");
	AST_NO_START: assert property (state_r == ST_IDLE && !active |=>
		state_r == ST_IDLE) else $error("Engine started while inactive");
	AST_LEN: assert property (mst_req_valid_out |-> mst_len_out != 3'h0 &&
		mst_len_out <= (ctrl_r[B_BURST] ? LEN_BURST : LEN_SINGLE))
		else $error("Transaction length wrong for burst setting");
	AST_RD_CMD: assert property (mst_req_valid_out && !dir_r |->
		mst_cmd_out == CMD_MEM_RD) else $error("Read not memory read");
	AST_WR_CMD: assert property (mst_req_valid_out && dir_r |->
		mst_cmd_out == CMD_MEM_WR) else $error("Write not memory write");
	AST_WR_FIRST: assert property ($rose(state_r == ST_WR_ISSUE) |->
		f_count == len_r) else $error("PCI write before FIFO filled");
	AST_RD_MATCH: assert property (is_rd_drn && !discard |->
		xfer_r == len_r) else $error("Drain count differs from fetch");
	AST_DONE: assert property (finish && !wr_adr |=> done_r && !loaded_r)
		else $error("Completion did not set done");
	AST_ZERO_BITS: assert property (ccs_rd[13:12] == 2'b00)
		else $error("Unused bits read nonzero");

endmodule

// File: tb/pdma_partner.sv
// Purpose: PCI master engine stand-in for the DMA sequencer
// Assumes: One transaction at a time, a beat every other cycle
// Notes:   Read data idles inverted so stale words show
module pdma_partner (
	input  wire logic        clock_in, // Clock
	input  wire logic        req_in,   // Request valid
	output logic             req_out,  // Request ready
	input  wire logic [3:0]  cmd_in,   // Bus command
	input  wire logic [2:0]  len_in,   // DWORDs asked
	output logic             rv_out,   // Read valid
	output logic [31:0]      rd_out,   // Read DWORD
	input  wire logic        rr_in,    // Read ready
	input  wire logic        wv_in,    // Write valid
	input  wire logic [31:0] wd_in,    // Write DWORD
	output logic             wr_out    // Write ready
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0]  cmd = '0;
	logic [2:0]  len = '0;
	logic [2:0]  pend = '0;
	logic [31:0] rd = 32'h1000_0000;
	logic [31:0] wd = '0;
	logic        rv = 1'b0;
	int          n_req = 0;
	int          n_wr = 0;
	initial req_out = 1'b0;
	initial wr_out = 1'b0;
	assign rv_out = rv;
	assign rd_out = rv ? rd : ~rd;
	// Take requests, then run the beats they ask for
	always @(posedge clock_in) begin
		req_out <= req_in && !req_out && pend == 0;
		if (req_in && req_out) begin
			cmd <= cmd_in;
			len <= len_in;
			pend <= len_in;
			n_req <= n_req + 1;
		end
		if (rv && rr_in) begin
			rv <= 1'b0;
			pend <= pend - 1;
			rd <= rd + 1;
		end else if (pend != 0 && cmd == 4'h6)
			rv <= 1'b1;
		if (wv_in && wr_out) begin
			wr_out <= 1'b0;
			pend <= pend - 1;
			wd <= wd_in;
			n_wr <= n_wr + 1;
		end else
			wr_out <= pend != 0 && cmd == 4'h7;
	end
endmodule

// File: tb/pdma_top_tb_top.sv
// Purpose: Self-checking bench of the DMA sequencer
// Assumes: Partner engine answers all PCI requests
// Notes:   Local receive side stalls every other cycle
module pdma_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import pdma_pkg::*;
	logic clock_in = 0, nrst_in = 0, awvalid_in = 0, wvalid_in = 0,
		bready_in = 0, arvalid_in = 0, rready_in = 0, loc_rx_ready_in = 0,
		loc_tx_valid_in = 0, mst_err_in = 0, loc_irq_req_in = 0, tk = 0;
	logic [7:0] awaddr_in = '0, araddr_in = '0;
	logic [3:0] wstrb_in = '0;
	logic [31:0] wdata_in = '0, loc_tx_data_in = '0, q;
	logic [1:0] rs;
	wire mst_req_ready_in, mst_rd_valid_in, mst_wr_ready_in;
	wire [31:0] mst_rd_data_in;
	logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out,
		mst_req_valid_out, mst_rd_ready_out, mst_wr_valid_out,
		loc_rx_valid_out, loc_tx_ready_out, loc_reset_n_out;
	logic [1:0] bresp_out, rresp_out;
	logic [31:0] rdata_out, mst_addr_out, mst_wr_data_out, loc_rx_data_out;
	logic [3:0] mst_cmd_out;
	logic [2:0] mst_len_out;
	int failures = 0, tests_run = 0, n_rx = 0, n_tx = 0, tx_n = 0;
	always #4 clock_in = ~clock_in;
	pdma_top pdma_top_inst (.*);
	pdma_partner pdma_partner_inst (.clock_in(clock_in),
		.req_in(mst_req_valid_out), .req_out(mst_req_ready_in),
		.cmd_in(mst_cmd_out), .len_in(mst_len_out), .rv_out(mst_rd_valid_in),
		.rd_out(mst_rd_data_in), .rr_in(mst_rd_ready_out),
		.wv_in(mst_wr_valid_out), .wd_in(mst_wr_data_out),
		.wr_out(mst_wr_ready_in));
	//////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("BAD %0t got %h exp %h", $time, g, e);
		end
	endtask
	task finish_test;
		if (failures == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// One AXI4-Lite transfer, handshakes judged between edges
	task bus(input bit w, input logic [7:0] a, input logic [31:0] d);
		bit ta, tw, td;
		int k;
		@(posedge clock_in);
		{awaddr_in, araddr_in, wdata_in, wstrb_in} <= {a, a, d, 4'hf};
		{awvalid_in, wvalid_in, bready_in} <= {w, w, w};
		{arvalid_in, rready_in} <= {!w, !w};
		for (k = 0; k < 99; k++) begin
			@(negedge clock_in);
			ta = awvalid_in & awready_out | arvalid_in & arready_out;
			tw = wvalid_in & wready_out;
			td = w ? bvalid_out : rvalid_out;
			rs = w ? bresp_out : rresp_out;
			q = rdata_out;
			@(posedge clock_in);
			if (ta)
				{awvalid_in, arvalid_in} <= 2'h0;
			if (tw)
				wvalid_in <= 1'b0;
			if (td)
				break;
		end
		{bready_in, rready_in} <= 2'h0;
		if (k == 99) begin
			failures++;
			finish_test;
		end
	endtask
	// Poll until done, then check status after completion
	task wdone;
		int k;
		q = '0;
		for (k = 0; k < 200 && q[10] !== 1'b1; k++)
			bus(0, OFS_CCS, 0);
		if (k == 200) begin
			failures++;
			finish_test;
		end
		chk(32'(q[11:9]), 32'h2);
		bus(0, OFS_CCS, 0);
		chk(32'(q[10]), 32'h0);
	endtask
	// Local side: receive with stalls, supply tx_n words
	always @(negedge clock_in) begin
		tk = loc_tx_valid_in & loc_tx_ready_out;
		if (loc_rx_valid_out & loc_rx_ready_in) begin
			chk(loc_rx_data_out, 32'h1000_0000 + n_rx);
			n_rx++;
		end
	end
	always @(posedge clock_in) begin
		loc_rx_ready_in <= ~loc_rx_ready_in;
		if (tk)
			n_tx++;
		loc_tx_valid_in <= n_tx < tx_n;
		loc_tx_data_in <= 32'hA000_0000 + n_tx;
	end
	initial begin
		q = '0;
		repeat (8) @(posedge clock_in);
		nrst_in <= 1'b1;
		bus(0, OFS_CCS, 0);
		chk(q, 32'h0);
		chk(32'(loc_reset_n_out), 32'h0);
		bus(0, 8'h0C, 0);
		chk(32'(rs), 32'(RESP_SLVERR));
		bus(1, OFS_CCS, 32'hFFFF_F000);
		bus(0, OFS_CCS, 0);
		chk(32'(q[31:12]), 32'hF_FFFC);
		bus(1, OFS_CCS, 32'h0000_0011);
		bus(1, OFS_ADDR, 32'h0000_2000);
		bus(0, OFS_CCS, 0);
		chk(32'(q[11:9]), 32'h5);
		chk(32'(loc_reset_n_out), 32'h1);
		bus(1, OFS_CCS, 32'h0000_0013);
		bus(0, OFS_CCS, 0);
		chk(32'(q[11:9]), 32'h0);
		// Pending error blocks the start although the address is loaded
		mst_err_in <= 1'b1;
		bus(1, OFS_CCS, 32'h0001_0011);
		bus(1, OFS_ADDR, 32'h0000_2000);
		bus(0, OFS_CCS, 0);
		chk(32'(q[11:7]), 32'h13);
		chk(pdma_partner_inst.n_req, 0);
		bus(1, OFS_CCS, 32'h0000_0013);
		mst_err_in <= 1'b0;
		bus(1, OFS_DIR, 0);
		bus(1, OFS_CCS, 32'h0001_0031);
		bus(1, OFS_ADDR, 32'h0000_1000);
		wdone;
		chk(n_rx, 4);
		chk(mst_addr_out, 32'h0000_1010);
		chk(32'(pdma_partner_inst.cmd), 32'(CMD_MEM_RD));
		chk(32'(pdma_partner_inst.len), 32'h4);
		tx_n = 2;
		bus(1, OFS_DIR, 1);
		bus(1, OFS_CCS, 32'h0000_8011);
		bus(1, OFS_ADDR, 32'h0000_3000);
		wdone;
		chk(pdma_partner_inst.n_wr, 2);
		chk(pdma_partner_inst.wd, 32'hA000_0001);
		chk(32'(pdma_partner_inst.cmd), 32'(CMD_MEM_WR));
		chk(pdma_partner_inst.n_req, 3);
		chk(mst_addr_out, 32'h0000_3008);
		finish_test;
	end
endmodule
